// ---- shared/pressure_flow_pkg.sv ----
package pressure_flow_pkg;

  // input register indices as seen by the read port
  localparam logic [15:0] IREG_PRESSURE = 16'h0001;
  localparam logic [15:0] IREG_FLOW_UPPER = 16'h0002;
  localparam logic [15:0] IREG_FLOW_LOWER = 16'h0003;
  localparam logic [15:0] IREG_AIR_SPEED = 16'h0004;
  localparam logic [15:0] IREG_OUTPUT_LEVEL = 16'h0005;
  localparam logic [15:0] IREG_MAX_FLOW_UPPER = 16'h0006;
  localparam logic [15:0] IREG_MAX_FLOW_LOWER = 16'h0007;
  localparam logic [15:0] IREG_SPAN_FLAG = 16'h0008;
  localparam logic [15:0] IREG_ALARM_FLAG = 16'h0009;
  localparam logic [15:0] IREG_FEEDBACK_MISSING = 16'h000A;
  localparam logic [15:0] IREG_SENSOR_FAILURE = 16'h000B;
  localparam logic [15:0] IREG_RESERVED_FIRST = 16'h000C;
  localparam logic [15:0] IREG_RESERVED_LAST = 16'h0014;

  // value of the velocity option that enables velocity measurement
  localparam logic [15:0] VELOCITY_ENABLED = 16'h0001;
  localparam logic [15:0] AIR_SPEED_MAX = 16'h012C;
  localparam logic [15:0] OUTPUT_LEVEL_MAX = 16'h03E8;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] FLAG_SET = 16'h0001;

  // integer square root of a 16-bit radicand, one result bit per cycle
  localparam logic [2:0] SQRT_TOP_BIT = 3'h7;
  localparam logic [7:0] SQRT_BIT_ONE = 8'h01;

  // red indicator flash timing
  localparam int unsigned CLOCK_KHZ = 100000;
  localparam int unsigned FLASH_HALF_PERIOD_MS = 250;
  localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_PERIOD_MS * CLOCK_KHZ;

  typedef enum logic [2:0] {
    ST_LOAD,
    ST_SQRT_MEAS,
    ST_STORE_MEAS,
    ST_SQRT_MAX,
    ST_STORE_MAX
  } calc_state_t;

endpackage

// ---- hdl/pressure_flow_input_regs.sv ----
`timescale 1ns/100ps
// What this block does
// - The 32-bit flow rate is read with its upper word at input register 2 and its lower word at register 3.
// - Flow rate equals the fan flow coefficient times the square root of the measured pressure difference.
// - With a zero flow coefficient, flow rate equals duct area times air speed, only when velocity is enabled.
// - Air speed reads non-zero only while the velocity option equals 1, and stays within 0 to 300.
// - The output level reads as an unsigned value from 0 to 1000.
// - Maximum flow is a word pair, from the coefficient and full-scale pressure or from area and top speed.
// - The span flag reads 1 while pressure, flow or, with velocity enabled, speed lies outside its span limits, else 0.
// - The alarm flag reads 1 while pressure, flow or, with velocity enabled, speed lies outside its alarm limits, else 0.
// - Both span and alarm flags stay 0 while self-tuning runs.
// - The feedback-missing flag follows lost pressure feedback and flashes the red indicator.
// - The sensing-failure flag follows a failed sensor element and flashes the red indicator.
module pressure_flow_input_regs
  import pressure_flow_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = FLASH_HALF_CYCLES
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic REG_RD_IN,
  input wire logic [15:0] REG_ADDR_IN,
  input wire logic [15:0] PRESSURE_IN,
  input wire logic [15:0] AIR_SPEED_IN,
  input wire logic [15:0] OUTPUT_LEVEL_IN,
  input wire logic [15:0] FLOW_COEFF_IN,
  input wire logic [15:0] DUCT_AREA_IN,
  input wire logic [15:0] VELOCITY_OPTION_IN,
  input wire logic [15:0] PRESSURE_FULL_SCALE_IN,
  input wire logic [15:0] PRESSURE_SPAN_MIN_IN,
  input wire logic [15:0] PRESSURE_SPAN_MAX_IN,
  input wire logic [15:0] FLOW_SPAN_MIN_IN,
  input wire logic [15:0] FLOW_SPAN_MAX_IN,
  input wire logic [15:0] SPEED_SPAN_MIN_IN,
  input wire logic [15:0] SPEED_SPAN_MAX_IN,
  input wire logic [15:0] PRESSURE_ALARM_MIN_IN,
  input wire logic [15:0] PRESSURE_ALARM_MAX_IN,
  input wire logic [15:0] FLOW_ALARM_MIN_IN,
  input wire logic [15:0] FLOW_ALARM_MAX_IN,
  input wire logic [15:0] SPEED_ALARM_MIN_IN,
  input wire logic [15:0] SPEED_ALARM_MAX_IN,
  input wire logic SELF_TUNE_IN,
  input wire logic FEEDBACK_LOST_IN,
  input wire logic SENSOR_FAULT_IN,
  output logic RD_VALID_OUT,
  output logic [15:0] RD_DATA_OUT,
  output logic RED_LED_OUT
);

  logic rst_meta;
  logic rst_n;
  calc_state_t state;
  logic [15:0] radicand;
  logic [7:0] root;
  logic [2:0] bit_idx;
  logic [15:0] coeff;
  logic [15:0] area;
  logic [31:0] flow_rate;
  logic [31:0] max_flow;
  logic [15:0] measured_pressure_difference;
  logic [15:0] measured_air_speed;
  logic [15:0] output_level_percent;
  logic span_violation_flag;
  logic alarm_violation_flag;
  logic pressure_feedback_missing;
  logic sensing_element_failure;
  logic [31:0] flash_count;
  logic [15:0] rd_addr;

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // measurement conditioning
  wire velocity_on = (VELOCITY_OPTION_IN == VELOCITY_ENABLED);
  wire [15:0] speed_clamped = (AIR_SPEED_IN > AIR_SPEED_MAX) ? AIR_SPEED_MAX : AIR_SPEED_IN;
  wire [15:0] next_speed = velocity_on ? speed_clamped : WORD_RESET;
  wire [15:0] next_level = (OUTPUT_LEVEL_IN > OUTPUT_LEVEL_MAX) ? OUTPUT_LEVEL_MAX : OUTPUT_LEVEL_IN;
  // negative pressure gives a zero root, so no coefficient-based flow
  wire [15:0] pressure_pos = PRESSURE_IN[15] ? WORD_RESET : PRESSURE_IN;

  // square root engine shared between live flow and maximum flow
  wire [7:0] root_try = root | (SQRT_BIT_ONE << bit_idx);
  wire [15:0] root_try_sq = root_try * root_try;
  wire keep_bit = (root_try_sq <= radicand);
  wire [7:0] next_root = keep_bit ? root_try : root;
  wire sqrt_busy = (state == ST_SQRT_MEAS) || (state == ST_SQRT_MAX);
  wire sqrt_last = (bit_idx == 3'h0);
  wire [23:0] coeff_root = coeff * root;
  wire [31:0] area_speed = area * measured_air_speed;
  wire [31:0] area_top_speed = area * AIR_SPEED_MAX;
  wire use_coeff = (coeff != WORD_RESET);
  wire [31:0] next_flow = use_coeff ? {8'h00, coeff_root} : (velocity_on ? area_speed : 32'h0000_0000);
  wire [31:0] next_max_flow = use_coeff ? {8'h00, coeff_root} : (velocity_on ? area_top_speed : 32'h0000_0000);

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_LOAD;
      radicand <= WORD_RESET;
      root <= 8'h00;
      bit_idx <= SQRT_TOP_BIT;
      coeff <= WORD_RESET;
      area <= WORD_RESET;
      flow_rate <= 32'h0000_0000;
      max_flow <= 32'h0000_0000;
    end else begin
      case (state)
        ST_LOAD: begin
          radicand <= pressure_pos;
          root <= 8'h00;
          bit_idx <= SQRT_TOP_BIT;
          coeff <= FLOW_COEFF_IN;
          area <= DUCT_AREA_IN;
          state <= ST_SQRT_MEAS;
        end
        ST_SQRT_MEAS, ST_SQRT_MAX: begin
          root <= next_root;
          bit_idx <= bit_idx - 3'h1;
          if (sqrt_last) begin
            state <= (state == ST_SQRT_MEAS) ? ST_STORE_MEAS : ST_STORE_MAX;
          end
        end
        ST_STORE_MEAS: begin
          flow_rate <= next_flow;
          radicand <= PRESSURE_FULL_SCALE_IN[15] ? WORD_RESET : PRESSURE_FULL_SCALE_IN;
          root <= 8'h00;
          bit_idx <= SQRT_TOP_BIT;
          state <= ST_SQRT_MAX;
        end
        ST_STORE_MAX: begin
          max_flow <= next_max_flow;
          state <= ST_LOAD;
        end
        default: begin
          state <= ST_LOAD;
        end
      endcase
    end
  end

  // limit checks, pressure signed, flow and speed unsigned
  wire pres_out_span = ($signed(measured_pressure_difference) < $signed(PRESSURE_SPAN_MIN_IN)) ||
    ($signed(measured_pressure_difference) > $signed(PRESSURE_SPAN_MAX_IN));
  wire pres_out_alarm = ($signed(measured_pressure_difference) < $signed(PRESSURE_ALARM_MIN_IN)) ||
    ($signed(measured_pressure_difference) > $signed(PRESSURE_ALARM_MAX_IN));
  wire flow_out_span = (flow_rate < {16'h0000, FLOW_SPAN_MIN_IN}) || (flow_rate > {16'h0000, FLOW_SPAN_MAX_IN});
  wire flow_out_alarm = (flow_rate < {16'h0000, FLOW_ALARM_MIN_IN}) || (flow_rate > {16'h0000, FLOW_ALARM_MAX_IN});
  wire speed_out_span = velocity_on &&
    ((measured_air_speed < SPEED_SPAN_MIN_IN) || (measured_air_speed > SPEED_SPAN_MAX_IN));
  wire speed_out_alarm = velocity_on &&
    ((measured_air_speed < SPEED_ALARM_MIN_IN) || (measured_air_speed > SPEED_ALARM_MAX_IN));
  wire next_span = !SELF_TUNE_IN && (pres_out_span || flow_out_span || speed_out_span);
  wire next_alarm = !SELF_TUNE_IN && (pres_out_alarm || flow_out_alarm || speed_out_alarm);

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      measured_pressure_difference <= WORD_RESET;
      measured_air_speed <= WORD_RESET;
      output_level_percent <= WORD_RESET;
      span_violation_flag <= 1'b0;
      alarm_violation_flag <= 1'b0;
      pressure_feedback_missing <= 1'b0;
      sensing_element_failure <= 1'b0;
    end else begin
      measured_pressure_difference <= PRESSURE_IN;
      measured_air_speed <= next_speed;
      output_level_percent <= next_level;
      span_violation_flag <= next_span;
      alarm_violation_flag <= next_alarm;
      pressure_feedback_missing <= FEEDBACK_LOST_IN;
      sensing_element_failure <= SENSOR_FAULT_IN;
    end
  end

  // red indicator flashes while either fault is present
  wire fault_any = pressure_feedback_missing || sensing_element_failure;
  wire flash_wrap = (flash_count == FLASH_CYCLES - 1);

  // counter parked at its wrap point so the first fault cycle lights the indicator, then equal on and off halves
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      flash_count <= 32'(FLASH_CYCLES - 1);
      RED_LED_OUT <= 1'b0;
    end else if (!fault_any) begin
      flash_count <= 32'(FLASH_CYCLES - 1);
      RED_LED_OUT <= 1'b0;
    end else begin
      flash_count <= flash_wrap ? 32'h0000_0000 : flash_count + 32'h0000_0001;
      if (flash_wrap) begin
        RED_LED_OUT <= !RED_LED_OUT;
      end
    end
  end

  // read port: one word per request, answered on the next edge
  wire [15:0] rd_word =
    (REG_ADDR_IN == IREG_PRESSURE) ? measured_pressure_difference :
    (REG_ADDR_IN == IREG_FLOW_UPPER) ? flow_rate[31:16] :
    (REG_ADDR_IN == IREG_FLOW_LOWER) ? flow_rate[15:0] :
    (REG_ADDR_IN == IREG_AIR_SPEED) ? measured_air_speed :
    (REG_ADDR_IN == IREG_OUTPUT_LEVEL) ? output_level_percent :
    (REG_ADDR_IN == IREG_MAX_FLOW_UPPER) ? max_flow[31:16] :
    (REG_ADDR_IN == IREG_MAX_FLOW_LOWER) ? max_flow[15:0] :
    (REG_ADDR_IN == IREG_SPAN_FLAG) ? {15'h0000, span_violation_flag} :
    (REG_ADDR_IN == IREG_ALARM_FLAG) ? {15'h0000, alarm_violation_flag} :
    (REG_ADDR_IN == IREG_FEEDBACK_MISSING) ? {15'h0000, pressure_feedback_missing} :
    (REG_ADDR_IN == IREG_SENSOR_FAILURE) ? {15'h0000, sensing_element_failure} :
    WORD_RESET;

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      RD_VALID_OUT <= 1'b0;
      RD_DATA_OUT <= WORD_RESET;
      rd_addr <= WORD_RESET;
    end else begin
      RD_VALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        RD_DATA_OUT <= rd_word;
        rd_addr <= REG_ADDR_IN;
      end
    end
  end

  wire reserved_addr = (rd_addr >= IREG_RESERVED_FIRST) && (rd_addr <= IREG_RESERVED_LAST);

  property p_flow_upper;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    REG_RD_IN && REG_ADDR_IN == IREG_FLOW_UPPER |=> RD_VALID_OUT && RD_DATA_OUT == $past(flow_rate[31:16]);
  endproperty
  a_flow_upper: assert property (p_flow_upper) else $error("flow upper word mismatch");

  property p_flow_lower;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    REG_RD_IN && REG_ADDR_IN == IREG_FLOW_LOWER |=> RD_DATA_OUT == $past(flow_rate[15:0]);
  endproperty
  a_flow_lower: assert property (p_flow_lower) else $error("flow lower word mismatch");

  property p_sqrt_exact;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    state == ST_STORE_MEAS |-> ({8'h00, root} * {8'h00, root} <= {16'h0000, radicand}) &&
      ({8'h00, root} + 16'h0001) * ({8'h00, root} + 16'h0001) > {16'h0000, radicand};
  endproperty
  a_sqrt_exact: assert property (p_sqrt_exact) else $error("square root out of bounds");

  property p_area_flow;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    state == ST_STORE_MEAS && coeff == WORD_RESET && !velocity_on |=> flow_rate == 32'h0000_0000;
  endproperty
  a_area_flow: assert property (p_area_flow) else $error("flow without coefficient or velocity");

  property p_speed_gated;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    $past(VELOCITY_OPTION_IN) != VELOCITY_ENABLED |-> measured_air_speed == WORD_RESET;
  endproperty
  a_speed_gated: assert property (p_speed_gated) else $error("air speed shown while disabled");

  property p_level_range;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    output_level_percent <= OUTPUT_LEVEL_MAX && measured_air_speed <= AIR_SPEED_MAX;
  endproperty
  a_level_range: assert property (p_level_range) else $error("value above its range");

  property p_tune_quiet;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    SELF_TUNE_IN |=> !span_violation_flag && !alarm_violation_flag;
  endproperty
  a_tune_quiet: assert property (p_tune_quiet) else $error("flag raised during self tuning");

  property p_fault_led;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    !FEEDBACK_LOST_IN && !SENSOR_FAULT_IN ##1 !FEEDBACK_LOST_IN && !SENSOR_FAULT_IN |=> !RED_LED_OUT;
  endproperty
  a_fault_led: assert property (p_fault_led) else $error("red indicator lit without fault");

  property p_sensor_flag;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    SENSOR_FAULT_IN && !sensing_element_failure && !pressure_feedback_missing |=>
      sensing_element_failure ##1 RED_LED_OUT;
  endproperty
  a_sensor_flag: assert property (p_sensor_flag) else $error("sensor failure not shown");

  property p_reserved_zero;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    RD_VALID_OUT && reserved_addr |-> RD_DATA_OUT == WORD_RESET;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved register not zero");

  property p_cycle_len;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    state == ST_LOAD |=> sqrt_busy [*8] ##1 state == ST_STORE_MEAS;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("square root step count wrong");

  c_flow_read: cover property (@(posedge CLOCK_IN) disable iff (!rst_n)
    REG_RD_IN && REG_ADDR_IN == IREG_FLOW_UPPER ##1 REG_RD_IN && REG_ADDR_IN == IREG_FLOW_LOWER);
  c_span_set: cover property (@(posedge CLOCK_IN) disable iff (!rst_n) $rose(span_violation_flag));
  c_alarm_set: cover property (@(posedge CLOCK_IN) disable iff (!rst_n) $rose(alarm_violation_flag));
  c_led_toggle: cover property (@(posedge CLOCK_IN) disable iff (!rst_n) $fell(RED_LED_OUT) && fault_any);

endmodule // pressure_flow_input_regs

// ---- dv/reg_reader_model.sv ----
`timescale 1ns/100ps
module reg_reader_model (
  input wire logic clk_in,
  input wire logic rd_valid_in,
  input wire logic [15:0] rd_data_in,
  output logic reg_rd_out,
  output logic [15:0] reg_addr_out
);
  initial begin
    reg_rd_out = 1'b0;
    reg_addr_out = 16'h0000;
  end
  // one word, or a word pair read back to back in consecutive cycles
  task automatic read(input logic [15:0] addr, input bit pair, output logic [15:0] hi, output logic [15:0] lo,
                      output logic ok);
    @(negedge clk_in);
    reg_rd_out <= 1'b1;
    reg_addr_out <= addr;
    @(negedge clk_in);
    hi = rd_data_in;
    lo = rd_data_in;
    ok = rd_valid_in;
    if (pair) begin
      reg_addr_out <= addr + 16'h0001;
      @(negedge clk_in);
      lo = rd_data_in;
      ok = ok & rd_valid_in;
    end
    reg_rd_out <= 1'b0;
    // a released address does not keep its last value
    reg_addr_out <= ~reg_addr_out;
  endtask
endmodule // reg_reader_model

// ---- dv/tb_pressure_flow_input_regs.sv ----
`timescale 1ns/100ps
module tb_pressure_flow_input_regs;
  import pressure_flow_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rd, valid, led, tune, fb_lost, fault;
  logic [15:0] addr, data, pres, speed, outl, coeff, area, vopt, fs;
  logic [15:0] psmn, psmx, fsmn, fsmx, ssmn, ssmx, pamn, pamx, famn, famx, samn, samx;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  pressure_flow_input_regs #(.FLASH_CYCLES(4)) uut (
    .CLOCK_IN(clk), .RST_N_IN(rst_n), .REG_RD_IN(rd), .REG_ADDR_IN(addr), .PRESSURE_IN(pres),
    .AIR_SPEED_IN(speed), .OUTPUT_LEVEL_IN(outl), .FLOW_COEFF_IN(coeff), .DUCT_AREA_IN(area),
    .VELOCITY_OPTION_IN(vopt), .PRESSURE_FULL_SCALE_IN(fs), .PRESSURE_SPAN_MIN_IN(psmn),
    .PRESSURE_SPAN_MAX_IN(psmx), .FLOW_SPAN_MIN_IN(fsmn), .FLOW_SPAN_MAX_IN(fsmx), .SPEED_SPAN_MIN_IN(ssmn),
    .SPEED_SPAN_MAX_IN(ssmx), .PRESSURE_ALARM_MIN_IN(pamn), .PRESSURE_ALARM_MAX_IN(pamx),
    .FLOW_ALARM_MIN_IN(famn), .FLOW_ALARM_MAX_IN(famx), .SPEED_ALARM_MIN_IN(samn), .SPEED_ALARM_MAX_IN(samx),
    .SELF_TUNE_IN(tune), .FEEDBACK_LOST_IN(fb_lost), .SENSOR_FAULT_IN(fault),
    .RD_VALID_OUT(valid), .RD_DATA_OUT(data), .RED_LED_OUT(led));

  reg_reader_model master (.clk_in(clk), .rd_valid_in(valid), .rd_data_in(data), .reg_rd_out(rd),
    .reg_addr_out(addr));

  task automatic end_of_test();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // reads one word or a pair and checks both words and the valid strobe
  task automatic rchk(input string what, input logic [15:0] a, input bit pair, input logic [31:0] exp);
    logic [15:0] hi, lo;
    logic ok;
    master.read(a, pair, hi, lo, ok);
    chk("rd_valid", 16'h0001, {15'h0000, ok});
    if (pair) chk(what, exp[31:16], hi);
    chk(what, exp[15:0], lo);
    cyc(1);
    chk("rd_valid_drop", 16'h0000, {15'h0000, valid});
  endtask

  task automatic t_reset();
    chk("data_in_reset", 16'h0000, data);
    chk("led_in_reset", 16'h0000, {15'h0000, led});
    chk("valid_in_reset", 16'h0000, {15'h0000, valid});
  endtask

  task automatic t_coeff_flow();
    coeff = 16'hFFFF;
    pres = 16'h4000;
    fs = 16'h2710;
    cyc(45);
    rchk("pressure", IREG_PRESSURE, 1'b0, 32'h0000_4000);
    rchk("flow", IREG_FLOW_UPPER, 1'b1, 32'h007F_FF80);
    rchk("max_flow", IREG_MAX_FLOW_UPPER, 1'b1, 32'h0063_FF9C);
    pres = 16'hFF9C;
    cyc(45);
    rchk("flow_neg", IREG_FLOW_UPPER, 1'b1, 32'h0000_0000);
    pres = 16'h0064;
    coeff = 16'h0001;
  endtask

  task automatic t_area_flow();
    coeff = 16'h0000;
    area = 16'h0002;
    vopt = 16'h0001;
    speed = 16'h012C;
    cyc(45);
    rchk("flow_area", IREG_FLOW_UPPER, 1'b1, 32'h0000_0258);
    rchk("max_area", IREG_MAX_FLOW_UPPER, 1'b1, 32'h0000_0258);
    rchk("speed", IREG_AIR_SPEED, 1'b0, 32'h0000_012C);
    vopt = 16'h0002;
    cyc(45);
    rchk("speed_off", IREG_AIR_SPEED, 1'b0, 32'h0000_0000);
    rchk("flow_off", IREG_FLOW_UPPER, 1'b1, 32'h0000_0000);
    vopt = 16'h0000;
    coeff = 16'h0001;
  endtask

  task automatic t_output();
    outl = 16'h03E8;
    cyc(2);
    rchk("output", IREG_OUTPUT_LEVEL, 1'b0, 32'h0000_03E8);
  endtask

  task automatic t_flags();
    cyc(45);
    rchk("span_ok", IREG_SPAN_FLAG, 1'b1, 32'h0000_0000);
    psmx = 16'h0032;
    cyc(3);
    rchk("span", IREG_SPAN_FLAG, 1'b1, 32'h0001_0000);
    pamx = 16'h0032;
    cyc(3);
    rchk("alarm", IREG_SPAN_FLAG, 1'b1, 32'h0001_0001);
    tune = 1'b1;
    cyc(3);
    rchk("tuning", IREG_SPAN_FLAG, 1'b1, 32'h0000_0000);
    tune = 1'b0;
    psmx = 16'h7FFF;
    pamx = 16'h7FFF;
  endtask

  task automatic t_faults();
    int toggles;
    int lit;
    logic last;
    toggles = 0;
    lit = 0;
    fault = 1'b1;
    cyc(3);
    rchk("sensor_fault", IREG_FEEDBACK_MISSING, 1'b1, 32'h0000_0001);
    last = led;
    for (int i = 0; i < 30; i++) begin
      cyc(1);
      if (led !== last) toggles++;
      if (led === 1'b1) lit++;
      last = led;
    end
    chk("led_flashing", 16'h0001, {15'h0000, toggles >= 2});
    // equal lit and dark halves of four cycles each
    chk("led_duty", 16'h0001, {15'h0000, lit >= 12 && lit <= 18});
    fault = 1'b0;
    fb_lost = 1'b1;
    cyc(3);
    rchk("feedback_lost", IREG_FEEDBACK_MISSING, 1'b1, 32'h0001_0000);
    fb_lost = 1'b0;
    cyc(12);
    chk("led_off", 16'h0000, {15'h0000, led});
  endtask

  task automatic t_reserved();
    for (logic [15:0] a = IREG_RESERVED_FIRST; a <= IREG_RESERVED_LAST; a++) begin
      rchk("reserved", a, 1'b0, 32'h0000_0000);
    end
  endtask

  initial begin
    {tune, fb_lost, fault} = 3'h0;
    {pres, speed, outl, area, vopt, fs} = {16'h0064, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064};
    coeff = 16'h0001;
    {psmn, pamn, psmx, pamx} = {16'h8000, 16'h8000, 16'h7FFF, 16'h7FFF};
    {fsmn, ssmn, famn, samn, fsmx, ssmx, famx, samx} = {64'h0, {4{16'hFFFF}}};
    cyc(3);
    t_reset();
    rst_n = 1'b1;
    cyc(4);
    t_coeff_flow();
    t_area_flow();
    t_output();
    t_flags();
    t_faults();
    t_reserved();
    end_of_test();
  end
endmodule // tb_pressure_flow_input_regs
